// [bench/sll_far_tx.sv]
// Far-side lane transmitter model: counted words and SYSREF
`timescale 1ns/10ps
module sll_far_tx (
    // Clock, reset and bench control
    input wire logic mclk,
    input wire logic rst,
    input wire logic [4:0] limit,
    input wire logic slow,
    input wire logic sysref_req,
    // Lane side
    output sll_pkg::sll_lanes_type phys_lanes,
    output logic phys_valid,
    input wire logic phys_ready,
    output logic sysref_pin
);
    logic [4:0] cnt_ff;
    logic gap_ff;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
            gap_ff <= 1'h0;
        end else begin
            gap_ff <= phys_valid && phys_ready && slow;
            if (phys_valid && phys_ready) begin
                cnt_ff <= cnt_ff + 5'h01;
            end
        end
    end
    // Limit only moves forward, so a raised valid holds until taken
    assign phys_valid = cnt_ff != limit && !gap_ff;
    always_comb begin
        for (int m = 0; m < 8; m++) begin
            // Idle lanes show the inverse so stale data never passes for a word
            phys_lanes.lane[m] = {cnt_ff, 3'(m)} ^ {8{!phys_valid}};
        end
    end
    assign sysref_pin = sysref_req;
endmodule : sll_far_tx

// [bench/sll_link_setup_props.sv]
// Assertion checker for the link layer setup block ports
`timescale 1ns/10ps
module sll_link_setup_props (
    // Clock, reset and register port
    input wire logic mclk,
    input wire logic rst,
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // Pins and lanes
    input wire logic lane_pll_lock_pin,
    input wire logic sysref_pin,
    input wire sll_pkg::sll_lanes_type phys_lanes,
    input wire logic phys_valid,
    input wire logic phys_ready,
    input wire sll_pkg::sll_lanes_type logic_lanes,
    input wire logic logic_valid,
    input wire logic logic_ready,
    // Link state
    input wire logic [1:0] link_active,
    input wire logic frame_sync_locked
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Pin must be steady over the two sync flops before the read can be judged
    property p_pll; reg_rd && reg_addr == 12'h281 && lane_pll_lock_pin == $past(lane_pll_lock_pin)
        && lane_pll_lock_pin == $past(lane_pll_lock_pin, 2) |=> reg_rdata[0] == $past(lane_pll_lock_pin);
    endproperty
    a_pll: assert property (p_pll) else $error("pll lock readback wrong");
    property p_lock; reg_rd && reg_addr == 12'h03B |=> reg_rdata[3] == $past(frame_sync_locked);
    endproperty
    a_lock: assert property (p_lock) else $error("lock readback wrong");
    property p_rv; reg_rd |=> reg_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("read answer missing");
    property p_norv; reg_rvalid |-> $past(reg_rd); endproperty
    a_norv: assert property (p_norv) else $error("stray read answer");
    property p_link; link_active != 2'h0 |-> frame_sync_locked; endproperty
    a_link: assert property (p_link) else $error("link active without lock");
    property p_rdy; phys_ready |-> link_active[0]; endproperty
    a_rdy: assert property (p_rdy) else $error("lanes taken with link 0 off");
    property p_push; phys_valid && phys_ready |=> logic_valid; endproperty
    a_push: assert property (p_push) else $error("word lost");
    property p_hold; logic_valid && !logic_ready |=> logic_valid && $stable(logic_lanes);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled word changed");
endmodule : sll_link_setup_props

bind sll_link_setup sll_link_setup_props sll_link_setup_props_inst (.mclk, .rst, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .lane_pll_lock_pin, .sysref_pin,
    .phys_lanes, .phys_valid, .phys_ready, .logic_lanes, .logic_valid, .logic_ready,
    .link_active, .frame_sync_locked);

// [bench/tb.sv]
// Self-checking testbench for the link layer setup block
`timescale 1ns/10ps
module tb;
    logic mclk = '0, rst = '1, reg_wr = '0, reg_rd = '0, pll_lock = '0, sysref_req = '0;
    logic slow = '0, logic_ready = '0, reg_rvalid, phys_valid, phys_ready, logic_valid;
    logic sysref_pin, locked;
    logic [11:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0, reg_rdata, mask = '0;
    logic [4:0] limit = '0, rx_cnt = '0;
    logic [1:0] link_active;
    sll_pkg::sll_lanes_type phys_lanes, logic_lanes;
    int err_total = 0, n_tests = 0, cyc = 0, i;
    logic [11:0] za [10] = '{12'h300, 12'h301, 12'h304, 12'h305, 12'h306, 12'h307, 12'h334,
        12'h03A, 12'h03B, 12'h123};
    logic [7:0] dv [4] = '{8'h04, 8'h00, 8'h5A, 8'hA5};
    logic [7:0] lc [4] = '{8'h01, 8'h05, 8'h0F, 8'h4B};
    logic [1:0] la [4] = '{2'h1, 2'h1, 2'h3, 2'h3};
    logic [7:0] xv [4] = '{8'h37, 8'h25, 8'h13, 8'h01};
    sll_link_setup sll_link_setup_inst (.mclk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .reg_rvalid, .lane_pll_lock_pin(pll_lock), .sysref_pin, .phys_lanes,
        .phys_valid, .phys_ready, .logic_lanes, .logic_valid, .logic_ready, .link_active,
        .frame_sync_locked(locked));
    sll_far_tx sll_far_tx_inst (.mclk, .rst, .limit, .slow, .sysref_req, .phys_lanes,
        .phys_valid, .phys_ready, .sysref_pin);
    initial begin
        forever #25 mclk = ~mclk;
    end
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = '1;
        @(negedge mclk);
        reg_wr = '0;
        @(negedge mclk);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
        reg_addr = a;
        reg_rd = '1;
        @(negedge mclk);
        reg_rd = '0;
        chk(64'(reg_rvalid), 64'h1);
        chk(64'(reg_rdata & m), 64'(e));
        @(negedge mclk);
    endtask : rd
    // Logical lane n comes from physical lane 7-n, inverted where the mask says
    function automatic logic [63:0] exp_word(input logic [4:0] k);
        for (int n = 0; n < 8; n++) exp_word[8*n +: 8] = {k, 3'(7 - n)} ^ {8{mask[n]}};
    endfunction : exp_word
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            conclude();
        end else if (!rst && logic_valid === 1'h1 && logic_ready) begin
            chk(logic_lanes, exp_word(rx_cnt));
            rx_cnt <= rx_cnt + 5'h01;
        end
    end
    initial begin
        repeat (12) @(negedge mclk);
        rst = '0;
        @(negedge mclk);
        wr(12'h03B, '1);
        wr(12'h123, '1);
        foreach (za[k]) rd(za[k], '0, '1);
        for (i = 0; i < 4; i++) rd(12'h308 + 12'(i), 8'h08 + 8'(i) * 8'h12, '1);
        for (i = 0; i < 4; i++) wr(12'h304 + 12'(i), dv[i]);
        for (i = 0; i < 4; i++) rd(12'h304 + 12'(i), dv[i], '1);
        rd(12'h281, '0, 8'h01);
        pll_lock = '1;
        repeat (3) @(negedge mclk);
        rd(12'h281, 8'h01, 8'h01);
        $display("register test done");
        wr(12'h301, 8'h01);
        wr(12'h03A, 8'h01);
        wr(12'h03A, 8'h81);
        wr(12'h03A, 8'hC1);
        repeat (10) @(negedge mclk);
        rd(12'h03B, '0, 8'h08);
        chk(64'(locked), 64'h0);
        sysref_req = '1;
        repeat (3) @(negedge mclk);
        sysref_req = '0;
        for (i = 0; i < 40 && locked !== 1'h1; i++) @(negedge mclk);
        chk(64'(locked), 64'h1);
        rd(12'h03B, 8'h08, 8'h08);
        rd(12'h03A, 8'h81, '1);
        $display("sync test done");
        for (i = 0; i < 4; i++) begin
            wr(12'h300, lc[i]);
            rd(12'h300, lc[i], '1);
            chk(64'(link_active), 64'(la[i]));
            rd(12'h03B, {4'h0, 1'h1, 2'h0, la[i][lc[i][2]]}, 8'h09);
        end
        $display("link test done");
        mask = 8'hA5;
        for (i = 0; i < 4; i++) wr(12'h308 + 12'(i), xv[i]);
        wr(12'h334, mask);
        limit = 5'h10;
        repeat (6) @(negedge mclk);
        // Receiver stalled: two words held, third refused
        chk(64'(phys_ready), 64'h0);
        chk(64'(logic_valid), 64'h1);
        chk(logic_lanes, exp_word(5'h00));
        logic_ready = '1;
        for (i = 0; i < 100 && rx_cnt != 5'h10; i++) @(negedge mclk);
        slow = '1;
        limit = 5'h18;
        for (i = 0; i < 100 && rx_cnt != 5'h18; i++) @(negedge mclk);
        chk(64'(rx_cnt), 64'h18);
        $display("stream test done");
        wr(12'h03A, 8'h01);
        chk(64'(locked), 64'h0);
        chk(64'(link_active), 64'h0);
        wr(12'h301, 8'h00);
        wr(12'h03A, 8'h81);
        wr(12'h03A, 8'hC1);
        for (i = 0; i < 40 && locked !== 1'h1; i++) @(negedge mclk);
        chk(64'(locked), 64'h1);
        rd(12'h03B, 8'h09, 8'h09);
        $display("subclass 0 test done");
        conclude();
    end
endmodule : tb

// [rtl/sll_link_setup.sv]
// Data link layer setup: registers, frame clock sync machine and lane remap path
`timescale 1ns/10ps
`include "sll_map.svh"

// Summary of operation
// - Lane PLL lock status reads as 1 in bit 0 of the PLL status register once the PLL locks.
// - The sync status lock bit reads 1 once the sync machine locks, after a SYSREF edge in subclass 1.
// - Each logical lane whose mask bit is 1 is bit-inverted, the others pass unchanged.
// - Four crossbar registers pick which physical lane feeds each logical lane.
// - Link control bit 2 selects whether the sync status link-up bit comes from link 0 or link 1.
// - The link enable field enables link 0, link 1 or both links, link 1 only while the dual-link bit is set; a sum bit sits beside them.
// - Fixed and variable frame clock delay values are each held in two registers.
module sll_link_setup (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [`SLL_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Asynchronous pins
    input wire logic lane_pll_lock_pin,
    input wire logic sysref_pin,
    // Physical lane input
    input wire sll_pkg::sll_lanes_type phys_lanes,
    input wire logic phys_valid,
    output logic phys_ready,
    // Logical lane output
    output sll_pkg::sll_lanes_type logic_lanes,
    output logic logic_valid,
    input wire logic logic_ready,
    // Link state
    output logic [1:0] link_active,
    output logic frame_sync_locked
);
    logic [7:0] sync_ctrl_ff;
    logic [7:0] link_ctrl_ff;
    logic [7:0] subclass_ff;
    logic [7:0] fix_a_ff;
    logic [7:0] fix_b_ff;
    logic [7:0] var_a_ff;
    logic [7:0] var_b_ff;
    logic [7:0] xbar_ff [0:3];
    logic [7:0] invert_ff;
    logic [7:0] reg_rdata_ff;
    logic reg_rvalid_ff;
    logic [1:0] pll_sync_ff;
    logic [1:0] sysref_sync_ff;
    logic sysref_prev_ff;
    logic sysref_edge;
    sll_pkg::sll_sync_state_type sync_state_ff;
    sll_pkg::sll_sync_state_type nxt_sync_state;
    logic [15:0] align_cnt_ff;
    logic [15:0] fixed_frame_clock_delay;
    logic lock_seen;
    logic [1:0] link_en;
    sll_pkg::sll_lanes_type mapped;
    sll_pkg::sll_lanes_type buf_ff [0:1];
    logic [1:0] buf_cnt_ff;
    logic buf_push;
    logic buf_pop;

    function automatic logic is_addr(input logic [`SLL_ADDR_W-1:0] a,
                                     input logic [`SLL_ADDR_W-1:0] off);
        is_addr = (a == off);
    endfunction : is_addr

    // Lane select for logical lane n: two 3-bit selects per crossbar byte
    function automatic logic [`SLL_SEL_W-1:0] lane_sel(input logic [7:0] xb, input logic hi);
        lane_sel = hi ? xb[5:3] : xb[2:0];
    endfunction : lane_sel

    // Crossbar bytes sit at four consecutive offsets from the first one
    function automatic logic xbar_hit(input logic [`SLL_ADDR_W-1:0] a, input int idx);
        xbar_hit = (a == `SLL_OFF_XBAR_0 + idx[`SLL_ADDR_W-1:0]);
    endfunction : xbar_hit

    // Pin synchronisers, one per pin; only the second flop feeds logic
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pll_sync_ff <= 2'h0;
        end else begin
            pll_sync_ff <= {pll_sync_ff[0], lane_pll_lock_pin};
        end
    end

    // Edge history resets low like the idle pin, so leaving reset makes no false edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sysref_sync_ff <= 2'h0;
            sysref_prev_ff <= 1'b0;
        end else begin
            sysref_sync_ff <= {sysref_sync_ff[0], sysref_pin};
            sysref_prev_ff <= sysref_sync_ff[1];
        end
    end

    assign sysref_edge = sysref_sync_ff[1] & ~sysref_prev_ff;

    // Configuration registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            link_ctrl_ff <= `SLL_RST_BYTE;
            subclass_ff <= `SLL_RST_BYTE;
            fix_a_ff <= `SLL_RST_BYTE;
            fix_b_ff <= `SLL_RST_BYTE;
            var_a_ff <= `SLL_RST_BYTE;
            var_b_ff <= `SLL_RST_BYTE;
            invert_ff <= `SLL_RST_BYTE;
        end else if (reg_wr) begin
            if (is_addr(reg_addr, `SLL_OFF_LINK_CTRL)) begin
                link_ctrl_ff <= reg_wdata;
            end
            if (is_addr(reg_addr, `SLL_OFF_SUBCLASS)) begin
                subclass_ff <= reg_wdata;
            end
            if (is_addr(reg_addr, `SLL_OFF_FIX_A)) begin
                fix_a_ff <= reg_wdata;
            end
            if (is_addr(reg_addr, `SLL_OFF_FIX_B)) begin
                fix_b_ff <= reg_wdata;
            end
            if (is_addr(reg_addr, `SLL_OFF_VAR_A)) begin
                var_a_ff <= reg_wdata;
            end
            if (is_addr(reg_addr, `SLL_OFF_VAR_B)) begin
                var_b_ff <= reg_wdata;
            end
            if (is_addr(reg_addr, `SLL_OFF_INVERT)) begin
                invert_ff <= reg_wdata;
            end
        end
    end

    // Crossbar registers; the reset map is the identity
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            xbar_ff[0] <= `SLL_XBAR_RST_0;
            xbar_ff[1] <= `SLL_XBAR_RST_1;
            xbar_ff[2] <= `SLL_XBAR_RST_2;
            xbar_ff[3] <= `SLL_XBAR_RST_3;
        end else if (reg_wr) begin
            for (int i = 0; i < 4; i++) begin
                if (xbar_hit(reg_addr, i)) begin
                    xbar_ff[i] <= reg_wdata;
                end
            end
        end
    end

    // Sync control: arm self-clears once the machine locks while the one-shot bit is set, so a new write is needed to rearm
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync_ctrl_ff <= `SLL_RST_BYTE;
        end else if (reg_wr && is_addr(reg_addr, `SLL_OFF_SYNC_CTRL)) begin
            sync_ctrl_ff <= reg_wdata;
        end else if (sync_state_ff == sll_pkg::SYNC_LOCKED
                     && sync_ctrl_ff[`SLL_SYNC_ONESHOT_BIT]) begin
            sync_ctrl_ff[`SLL_SYNC_ARM_BIT] <= 1'b0;
        end
    end

    // Sync machine; subclass 0 needs no SYSREF and locks once the fixed delay runs out after arming
    always_comb begin
        nxt_sync_state = sync_state_ff;
        case (sync_state_ff)
            sll_pkg::SYNC_IDLE: begin
                if (sync_ctrl_ff[`SLL_SYNC_EN_BIT] && sync_ctrl_ff[`SLL_SYNC_ARM_BIT]) begin
                    nxt_sync_state = sll_pkg::SYNC_ARMED;
                end
            end
            sll_pkg::SYNC_ARMED: begin
                if (subclass_ff != `SLL_SUBCLASS_ONE || sysref_edge) begin
                    nxt_sync_state = sll_pkg::SYNC_ALIGN;
                end
            end
            sll_pkg::SYNC_ALIGN: begin
                if (align_cnt_ff == 16'h0000) begin
                    nxt_sync_state = sll_pkg::SYNC_LOCKED;
                end
            end
            sll_pkg::SYNC_LOCKED: begin
                nxt_sync_state = sll_pkg::SYNC_LOCKED;
            end
            default: begin
                nxt_sync_state = sll_pkg::SYNC_IDLE;
            end
        endcase
        if (!sync_ctrl_ff[`SLL_SYNC_EN_BIT]) begin
            nxt_sync_state = sll_pkg::SYNC_IDLE;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync_state_ff <= sll_pkg::SYNC_IDLE;
        end else begin
            sync_state_ff <= nxt_sync_state;
        end
    end

    assign fixed_frame_clock_delay = {fix_b_ff, fix_a_ff};

    // Alignment wait uses the fixed delay; the variable delay is only stored for register readback
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            align_cnt_ff <= 16'h0000;
        end else if (sync_state_ff == sll_pkg::SYNC_ARMED) begin
            align_cnt_ff <= fixed_frame_clock_delay;
        end else if (align_cnt_ff != 16'h0000) begin
            align_cnt_ff <= align_cnt_ff - 16'h0001;
        end
    end

    assign lock_seen = (sync_state_ff == sll_pkg::SYNC_LOCKED);
    assign frame_sync_locked = lock_seen;

    // Dual-link off forces link 1 down even if its enable bit is set
    assign link_en[0] = link_ctrl_ff[`SLL_LINK_EN_LSB];
    assign link_en[1] = link_ctrl_ff[`SLL_LINK_EN_MSB]
                        & link_ctrl_ff[`SLL_LINK_DUAL_BIT];
    assign link_active = link_en & {2{lock_seen}};

    // Register readback, one cycle after the read strobe; unmapped addresses read zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata_ff <= 8'h00;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_rd;
            if (reg_rd) begin
                reg_rdata_ff <= 8'h00;
                case (reg_addr)
                    `SLL_OFF_SYNC_CTRL: reg_rdata_ff <= sync_ctrl_ff;
                    `SLL_OFF_SYNC_STAT: begin
                        reg_rdata_ff[`SLL_SYNC_LOCK_BIT] <= lock_seen;
                        reg_rdata_ff[`SLL_SYNC_LINKUP_BIT] <=
                            link_active[link_ctrl_ff[`SLL_LINK_SEL_BIT]];
                    end
                    `SLL_OFF_PLL_STAT: reg_rdata_ff[`SLL_PLL_LOCK_BIT] <= pll_sync_ff[1];
                    `SLL_OFF_LINK_CTRL: reg_rdata_ff <= link_ctrl_ff;
                    `SLL_OFF_SUBCLASS: reg_rdata_ff <= subclass_ff;
                    `SLL_OFF_FIX_A: reg_rdata_ff <= fix_a_ff;
                    `SLL_OFF_FIX_B: reg_rdata_ff <= fix_b_ff;
                    `SLL_OFF_VAR_A: reg_rdata_ff <= var_a_ff;
                    `SLL_OFF_VAR_B: reg_rdata_ff <= var_b_ff;
                    `SLL_OFF_INVERT: reg_rdata_ff <= invert_ff;
                    default: begin
                        for (int i = 0; i < 4; i++) begin
                            if (xbar_hit(reg_addr, i)) begin
                                reg_rdata_ff <= xbar_ff[i];
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign reg_rdata = reg_rdata_ff;
    assign reg_rvalid = reg_rvalid_ff;

    // Crossbar then polarity, per logical lane
    for (genvar n = 0; n < sll_pkg::LANES; n++) begin : g_lane
        logic [`SLL_SEL_W-1:0] sel;
        assign sel = lane_sel(xbar_ff[n/2], (n % 2) == 1);
        assign mapped.lane[n] = phys_lanes.lane[sel] ^ {sll_pkg::LANE_W{invert_ff[n]}};
    end

    // Two-entry buffer; lanes only enter while link 0 is up, held words leave whether or not it is
    assign phys_ready = (buf_cnt_ff != 2'h2) & link_active[0];
    assign buf_push = phys_valid & phys_ready;
    assign logic_valid = (buf_cnt_ff != 2'h0);
    assign buf_pop = logic_valid & logic_ready;
    assign logic_lanes = buf_ff[0];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            buf_cnt_ff <= 2'h0;
        end else begin
            buf_cnt_ff <= buf_cnt_ff + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    // Words shift toward the head on a pop, so the head always holds the oldest
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            buf_ff[0] <= '0;
            buf_ff[1] <= '0;
        end else begin
            if (buf_pop) begin
                buf_ff[0] <= buf_ff[1];
            end
            if (buf_push) begin
                if (buf_cnt_ff == 2'h0 || (buf_cnt_ff == 2'h1 && buf_pop)) begin
                    buf_ff[0] <= mapped;
                end else begin
                    buf_ff[1] <= mapped;
                end
            end
        end
    end
endmodule : sll_link_setup

// [rtl/sll_map.svh]
// Register offsets, field positions, reset values and timing counts of the link layer setup
`ifndef SLL_MAP_SVH
`define SLL_MAP_SVH
`define SLL_ADDR_W 12
`define SLL_OFF_SYNC_CTRL 12'h03A
`define SLL_OFF_SYNC_STAT 12'h03B
`define SLL_OFF_PLL_STAT 12'h281
`define SLL_OFF_LINK_CTRL 12'h300
`define SLL_OFF_SUBCLASS 12'h301
`define SLL_OFF_FIX_A 12'h304
`define SLL_OFF_FIX_B 12'h305
`define SLL_OFF_VAR_A 12'h306
`define SLL_OFF_VAR_B 12'h307
`define SLL_OFF_XBAR_0 12'h308
`define SLL_OFF_XBAR_3 12'h30B
`define SLL_OFF_INVERT 12'h334
`define SLL_SYNC_ONESHOT_BIT 0
`define SLL_SYNC_ARM_BIT 6
`define SLL_SYNC_EN_BIT 7
`define SLL_SYNC_LOCK_BIT 3
`define SLL_SYNC_LINKUP_BIT 0
`define SLL_PLL_LOCK_BIT 0
`define SLL_LINK_EN_LSB 0
`define SLL_LINK_EN_MSB 1
`define SLL_LINK_SEL_BIT 2
`define SLL_LINK_DUAL_BIT 3
`define SLL_LINK_SUM_BIT 6
`define SLL_SUBCLASS_ONE 8'h01
`define SLL_RST_BYTE 8'h00
`define SLL_XBAR_RST_0 8'h08
`define SLL_XBAR_RST_1 8'h1A
`define SLL_XBAR_RST_2 8'h2C
`define SLL_XBAR_RST_3 8'h3E
`define SLL_SEL_W 3
`define SLL_MIN_DELAY 8'h01
`endif

// [rtl/sll_pkg.sv]
// Types shared by the link layer setup block
package sll_pkg;
    localparam int LANES = 8;
    localparam int LANE_W = 8;

    typedef logic [LANE_W-1:0] sll_lane_type;

    typedef struct packed {
        sll_lane_type [LANES-1:0] lane;
    } sll_lanes_type;

    typedef enum logic [3:0] {
        SYNC_IDLE = 4'h1,
        SYNC_ARMED = 4'h2,
        SYNC_ALIGN = 4'h4,
        SYNC_LOCKED = 4'h8
    } sll_sync_state_type;
endpackage : sll_pkg
